// *** verilog/hk_adc_pkg.sv ***
// Package for the housekeeping converter sequencer: register map, field positions, types.
// Assumes an 8-bit special function register bus and three external 8-bit converters.
`default_nettype none
package hk_adc_pkg;
    // Register byte addresses
    localparam logic [7:0] TEMPERATURE_RESULT_ADDR      = 8'hD7;
    localparam logic [7:0] CONVERSION_START_ADDR        = 8'hD8;
    localparam logic [7:0] BATTERY_RESULT_ADDR          = 8'hDF;
    localparam logic [7:0] POWER_EVENT_ENABLE_ADDR      = 8'hEC;
    localparam logic [7:0] EXTERNAL_VOLTAGE_RESULT_ADDR = 8'hEF;
    localparam logic [7:0] CHANGE_DELTA_CONFIG_ADDR     = 8'hF3;
    localparam logic [7:0] POWER_EVENT_FLAGS_ADDR       = 8'hF8;
    localparam logic [7:0] BACKGROUND_INTERVAL_ADDR     = 8'hF9;
    localparam logic [7:0] LOW_BATTERY_THRESHOLD_ADDR   = 8'hFA;

    // Reset value shared by every register
    localparam logic [7:0] REG_RESET = 8'h00;

    // Channel numbering matches the start bit positions
    localparam int NUM_CH   = 3;
    localparam int CH_BATT  = 0;
    localparam int CH_TEMP  = 1;
    localparam int CH_VDC   = 2;

    // Start register: valid start bits
    localparam logic [2:0] START_MASK = 3'h7;

    // Flag and enable bit positions
    localparam int LOW_BATTERY_FLAG_BIT       = 2;
    localparam int EXTERNAL_VOLTAGE_FLAG_BIT  = 3;

    // Delta field positions and special codes
    localparam int TEMP_DELTA_LSB = 3;
    localparam int VDC_DELTA_LSB  = 0;
    localparam logic [2:0] DELTA_OFF   = 3'h0;
    localparam logic [2:0] DELTA_EVERY = 3'h7;

    // Interval field positions (two bits each, code counts base strobe ticks)
    localparam int TEMP_INTERVAL_LSB = 0;
    localparam int VDC_INTERVAL_LSB  = 2;
    localparam int BATT_INTERVAL_LSB = 4;

    // Power-saving modes
    typedef enum logic [1:0] {
        full_power_mode,
        battery_active_mode,
        halted_sleep_mode
    } power_mode_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_t;

    // Converter completion report
    typedef struct packed {
        logic       done;
        logic [7:0] code;
    } adc_done_t;
endpackage : hk_adc_pkg
`default_nettype wire

// *** verilog/housekeeping_adc_sequencer.sv ***
// Sequencer for the temperature, battery and external voltage housekeeping converters.
// Assumes converters on the same clock: a request level, a one-cycle accept and a
// one-cycle done with an 8-bit code; a base strobe tick from the timer logic.
`default_nettype none

module housekeeping_adc_sequencer
    import hk_adc_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // Register bus
    input  wire sfr_req_t              sfrReq,
    output logic [7:0]                 sfrRdata,
    // Operating mode and base strobe
    input  wire power_mode_t           powerMode,
    input  wire logic                  strobeTick,
    // Converters, index 0 battery, 1 temperature, 2 external voltage
    output logic [NUM_CH-1:0]          convRequest,
    input  wire logic [NUM_CH-1:0]     convAccept,
    input  wire adc_done_t             convDone [NUM_CH],
    // Interrupt outputs
    output logic                       temperatureIrq,
    output logic                       externalVoltageIrq,
    output logic                       powerEventIrq
);

    // Register storage
    logic [2:0]        startBits_ff;
    logic [7:0]        powerEventEnable_ff;
    logic [7:0]        changeDeltaConfig_ff;
    logic [7:0]        backgroundInterval_ff;
    logic [7:0]        lowBatteryThreshold_ff;
    logic              lowBatteryFlag_ff;
    logic              externalVoltageFlag_ff;
    logic [7:0]        result_ff    [NUM_CH];
    logic [7:0]        reference_ff [NUM_CH];
    logic [7:0]        sfrRdata_ff;
    logic              temperatureIrq_ff;
    logic              externalVoltageIrq_ff;

    // Per-channel sequencing state
    logic [NUM_CH-1:0] bgPending_ff;
    logic [NUM_CH-1:0] busy_ff;
    logic [NUM_CH-1:0] busySingle_ff;
    logic [1:0]        tickCount_ff [NUM_CH];

    // Per-channel derived terms
    logic [1:0]        intervalCode [NUM_CH];
    logic [NUM_CH-1:0] allowSingle;
    logic [NUM_CH-1:0] allowBackground;
    logic [NUM_CH-1:0] singleDone;
    logic [NUM_CH-1:0] backgroundDone;
    logic [NUM_CH-1:0] eventFire;

    logic              wrStart;
    logic              wrFlags;
    logic              tempDeltaHit;
    logic              vdcDeltaHit;
    logic              battBelow;

    // Delta comparison on the 3-bit code
    // Difference taken from the larger value, so a wrap below zero never looks small
    // Codes one to six compare strictly greater: a change equal to the setting stays quiet
    function automatic logic delta_exceeded(input logic [7:0] code,
                                            input logic [7:0] ref_code,
                                            input logic [2:0] setting);
        logic [7:0] diff;
        diff = (code > ref_code) ? code - ref_code : ref_code - code;
        if (setting == DELTA_OFF)
            delta_exceeded = 1'b0;
        else if (setting == DELTA_EVERY)
            delta_exceeded = 1'b1;
        else
            delta_exceeded = diff > {5'h00, setting};
    endfunction : delta_exceeded

    // Write strobes decoded once; the bus has no wait states
    assign wrStart = sfrReq.wr && (sfrReq.addr == CONVERSION_START_ADDR);
    assign wrFlags = sfrReq.wr && (sfrReq.addr == POWER_EVENT_FLAGS_ADDR);

    // Interval fields per channel
    assign intervalCode[CH_BATT] = backgroundInterval_ff[BATT_INTERVAL_LSB +: 2];
    assign intervalCode[CH_TEMP] = backgroundInterval_ff[TEMP_INTERVAL_LSB +: 2];
    assign intervalCode[CH_VDC]  = backgroundInterval_ff[VDC_INTERVAL_LSB +: 2];

    // Mode gating; the battery path is idle in halted sleep
    // Mask bits follow channel order: battery, temperature, external voltage
    // Unused mode code gives all-off, so a bad mode value never starts a conversion
    always_comb
    begin
        allowSingle     = '0;
        allowBackground = '0;
        case (powerMode)
            full_power_mode:
            begin
                allowSingle     = 3'h7;
                allowBackground = 3'h7;
            end
            battery_active_mode:
            begin
                allowSingle     = 3'h7;
                allowBackground = 3'h0;
            end
            halted_sleep_mode:
            begin
                allowSingle     = 3'h0;
                allowBackground = 3'h6;
            end
            default:
            begin
                allowSingle     = 3'h0;
                allowBackground = 3'h0;
            end
        endcase
    end

    // Completion qualifiers per channel
    assign tempDeltaHit = delta_exceeded(convDone[CH_TEMP].code, reference_ff[CH_TEMP],
                                         changeDeltaConfig_ff[TEMP_DELTA_LSB +: 3]);
    assign vdcDeltaHit  = delta_exceeded(convDone[CH_VDC].code, reference_ff[CH_VDC],
                                         changeDeltaConfig_ff[VDC_DELTA_LSB +: 3]);
    assign battBelow    = convDone[CH_BATT].code < lowBatteryThreshold_ff;

    assign eventFire[CH_BATT] = singleDone[CH_BATT] || (backgroundDone[CH_BATT] && battBelow);
    assign eventFire[CH_TEMP] = singleDone[CH_TEMP] || (backgroundDone[CH_TEMP] && tempDeltaHit);
    assign eventFire[CH_VDC]  = singleDone[CH_VDC] || (backgroundDone[CH_VDC] && vdcDeltaHit);

    // Per-channel request, acceptance and background timing
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_chan
            logic wantSingle;
            logic wantBackground;

            assign wantSingle     = startBits_ff[ch] && allowSingle[ch];
            assign wantBackground = bgPending_ff[ch] && allowBackground[ch];
            // Request held as a level until the converter accepts it
            assign convRequest[ch]    = !busy_ff[ch] && (wantSingle || wantBackground);
            assign singleDone[ch]     = busy_ff[ch] && convDone[ch].done && busySingle_ff[ch];
            assign backgroundDone[ch] = busy_ff[ch] && convDone[ch].done && !busySingle_ff[ch];

            // Interval counter in base ticks; a zero code keeps it idle
            // Shortening the interval mid-count fires on the next tick, never skips a run
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    tickCount_ff[ch] <= 2'h0;
                else if (intervalCode[ch] == 2'h0)
                    tickCount_ff[ch] <= 2'h0;
                else if (strobeTick && (tickCount_ff[ch] + 2'h1 >= intervalCode[ch]))
                    tickCount_ff[ch] <= 2'h0;
                else if (strobeTick)
                    tickCount_ff[ch] <= tickCount_ff[ch] + 2'h1;
            end

            // Background due flag; dropped when the mode forbids it so no stale run appears later
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    bgPending_ff[ch] <= 1'b0;
                else if (intervalCode[ch] == 2'h0 || !allowBackground[ch])
                    bgPending_ff[ch] <= 1'b0;
                else if (strobeTick && (tickCount_ff[ch] + 2'h1 >= intervalCode[ch]))
                    bgPending_ff[ch] <= 1'b1;
                else if (convAccept[ch] && convRequest[ch] && !wantSingle)
                    bgPending_ff[ch] <= 1'b0;
            end

            // Conversion in flight and its kind; a single request wins over background
            // A done pulse with nothing in flight is ignored by the completion qualifiers
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    busy_ff[ch]       <= 1'b0;
                    busySingle_ff[ch] <= 1'b0;
                end
                else if (convAccept[ch] && convRequest[ch])
                begin
                    busy_ff[ch]       <= 1'b1;
                    busySingle_ff[ch] <= wantSingle;
                end
                else if (convDone[ch].done)
                    busy_ff[ch] <= 1'b0;
            end

            // Result loads only on an event; reference follows it
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    result_ff[ch]    <= REG_RESET;
                    reference_ff[ch] <= REG_RESET;
                end
                else if (eventFire[ch])
                begin
                    result_ff[ch]    <= convDone[ch].code;
                    reference_ff[ch] <= convDone[ch].code;
                end
            end
        end
    endgenerate

    // Start bits: software sets, acceptance clears; a new write wins over the clear
    // A start in a forbidding mode stays set and runs once the mode permits it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            startBits_ff <= 3'h0;
        else
            startBits_ff <= (startBits_ff & ~(convAccept & convRequest & startBits_ff & allowSingle))
                          | (wrStart ? (sfrReq.wdata[2:0] & START_MASK) : 3'h0);
    end

    // Plain read-write configuration registers
    // Writes to result registers fall through and are ignored
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            powerEventEnable_ff    <= REG_RESET;
            changeDeltaConfig_ff   <= REG_RESET;
            backgroundInterval_ff  <= REG_RESET;
            lowBatteryThreshold_ff <= REG_RESET;
        end
        else if (sfrReq.wr)
        begin
            if (sfrReq.addr == POWER_EVENT_ENABLE_ADDR)
                powerEventEnable_ff <= sfrReq.wdata;
            else if (sfrReq.addr == CHANGE_DELTA_CONFIG_ADDR)
                changeDeltaConfig_ff <= sfrReq.wdata;
            else if (sfrReq.addr == BACKGROUND_INTERVAL_ADDR)
                backgroundInterval_ff <= sfrReq.wdata;
            else if (sfrReq.addr == LOW_BATTERY_THRESHOLD_ADDR)
                lowBatteryThreshold_ff <= sfrReq.wdata;
        end
    end

    // Power event flags: writing zero clears, hardware set wins in the same cycle
    // Separate bits, so one clear write can drop one source and keep the other
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lowBatteryFlag_ff      <= 1'b0;
            externalVoltageFlag_ff <= 1'b0;
        end
        else
        begin
            if (eventFire[CH_BATT])
                lowBatteryFlag_ff <= 1'b1;
            else if (wrFlags && !sfrReq.wdata[LOW_BATTERY_FLAG_BIT])
                lowBatteryFlag_ff <= 1'b0;
            if (backgroundDone[CH_VDC] && vdcDeltaHit)
                externalVoltageFlag_ff <= 1'b1;
            else if (wrFlags && !sfrReq.wdata[EXTERNAL_VOLTAGE_FLAG_BIT])
                externalVoltageFlag_ff <= 1'b0;
        end
    end

    // Direct interrupt pulses; temperature keeps no flag at all
    // Registered for a clean pulse, at the cost of one cycle after done
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            temperatureIrq_ff     <= 1'b0;
            externalVoltageIrq_ff <= 1'b0;
        end
        else
        begin
            temperatureIrq_ff     <= eventFire[CH_TEMP];
            externalVoltageIrq_ff <= singleDone[CH_VDC];
        end
    end

    // Power interrupt level from enabled flags
    // Combinational so clearing an enable drops the request at once
    assign powerEventIrq = (lowBatteryFlag_ff && powerEventEnable_ff[LOW_BATTERY_FLAG_BIT])
                        || (externalVoltageFlag_ff && powerEventEnable_ff[EXTERNAL_VOLTAGE_FLAG_BIT]);
    assign temperatureIrq     = temperatureIrq_ff;
    assign externalVoltageIrq = externalVoltageIrq_ff;

    // Registered read data, one cycle after the read strobe; unmapped reads give zero
    // Limitation: start bits read back pending requests, not the converter state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sfrRdata_ff <= REG_RESET;
        else if (sfrReq.rd)
        begin
            if (sfrReq.addr == TEMPERATURE_RESULT_ADDR)
                sfrRdata_ff <= result_ff[CH_TEMP];
            else if (sfrReq.addr == CONVERSION_START_ADDR)
                sfrRdata_ff <= {5'h00, startBits_ff};
            else if (sfrReq.addr == BATTERY_RESULT_ADDR)
                sfrRdata_ff <= result_ff[CH_BATT];
            else if (sfrReq.addr == POWER_EVENT_ENABLE_ADDR)
                sfrRdata_ff <= powerEventEnable_ff;
            else if (sfrReq.addr == EXTERNAL_VOLTAGE_RESULT_ADDR)
                sfrRdata_ff <= result_ff[CH_VDC];
            else if (sfrReq.addr == CHANGE_DELTA_CONFIG_ADDR)
                sfrRdata_ff <= changeDeltaConfig_ff;
            else if (sfrReq.addr == POWER_EVENT_FLAGS_ADDR)
                sfrRdata_ff <= {4'h0, externalVoltageFlag_ff, lowBatteryFlag_ff, 2'h0};
            else if (sfrReq.addr == BACKGROUND_INTERVAL_ADDR)
                sfrRdata_ff <= backgroundInterval_ff;
            else if (sfrReq.addr == LOW_BATTERY_THRESHOLD_ADDR)
                sfrRdata_ff <= lowBatteryThreshold_ff;
            else
                sfrRdata_ff <= REG_RESET;
        end
    end

    assign sfrRdata = sfrRdata_ff;

endmodule : housekeeping_adc_sequencer
`default_nettype wire

// *** tb/hk_adc_chk.sv ***
// Port checker for the housekeeping converter sequencer.
// Assumes it is bound onto housekeeping_adc_sequencer with one clock domain.
`default_nettype none
module hk_adc_chk
    import hk_adc_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset_n,
    // Bus, mode and strobe
    input wire sfr_req_t          sfrReq,
    input wire logic [7:0]        sfrRdata,
    input wire power_mode_t       powerMode,
    input wire logic              strobeTick,
    // Converters
    input wire logic [NUM_CH-1:0] convRequest,
    input wire logic [NUM_CH-1:0] convAccept,
    input wire adc_done_t         convDone [NUM_CH],
    // Interrupts
    input wire logic              temperatureIrq,
    input wire logic              externalVoltageIrq,
    input wire logic              powerEventIrq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Request handshakes and mode gating
    batt_req_drop_a: assert property (convRequest[0] && convAccept[0] |=> !convRequest[0])
        else $error("battery request still high after accept");
    temp_req_drop_a: assert property ($past(convRequest[1] && convAccept[1]) |-> !convRequest[1])
        else $error("temperature request still high after accept");
    halted_batt_a: assert property (powerMode == halted_sleep_mode |-> !convRequest[0])
        else $error("battery request in halted sleep");
    // Interrupt causes, one cycle after a completion
    temp_irq_cause_a: assert property (temperatureIrq |-> $past(convDone[1].done))
        else $error("temperature interrupt without completion");
    vdc_irq_cause_a: assert property (externalVoltageIrq |-> $past(convDone[2].done))
        else $error("voltage interrupt without completion");
    temp_pulse_a: assert property (temperatureIrq |=> !temperatureIrq)
        else $error("temperature interrupt held as a level");
    event_cause_a: assert property ($rose(powerEventIrq) |-> $past(convDone[0].done || convDone[2].done || sfrReq.wr))
        else $error("power event without flag or enable change");
    // Read data only moves on a read
    rdata_hold_a: assert property (!$past(sfrReq.rd) |-> $stable(sfrRdata))
        else $error("read data changed without a read");

    temp_irq_c: cover property (temperatureIrq);
    vdc_irq_c: cover property (externalVoltageIrq);
    event_c: cover property (powerEventIrq);
endmodule : hk_adc_chk

bind housekeeping_adc_sequencer hk_adc_chk chk (.clk, .reset_n, .sfrReq, .sfrRdata, .powerMode, .strobeTick,
    .convRequest, .convAccept, .convDone, .temperatureIrq, .externalVoltageIrq, .powerEventIrq);
`default_nettype wire

// *** tb/housekeeping_adc_sequencer_test.sv ***
// Self-checking bench for the housekeeping converter sequencer.
// Bench acts as bus master and as all three converters; an inline model gives expectations.
`default_nettype none
module housekeeping_adc_sequencer_test
    import hk_adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Design connections
    logic              clk;
    logic              reset_n;
    sfr_req_t          sfrReq;
    logic [7:0]        sfrRdata;
    power_mode_t       powerMode;
    logic              strobeTick;
    logic [NUM_CH-1:0] convRequest;
    logic [NUM_CH-1:0] convAccept;
    adc_done_t         convDone [NUM_CH];
    logic              temperatureIrq;
    logic              externalVoltageIrq;
    logic              powerEventIrq;
    // Model state, indexed like the channels
    logic [7:0]        res [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0]        refs [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0]        resAddr [3] = '{8'hDF, 8'hD7, 8'hEF};
    logic [7:0]        addrs [10] = '{8'hD7, 8'hD8, 8'hDF, 8'hEC, 8'hEF, 8'hF3, 8'hF8, 8'hF9, 8'hFA, 8'hE0};
    int                fails = 0;
    int                check_count = 0;
    int                cycles = 0;
    int                seed;

    housekeeping_adc_sequencer DUT (.clk, .reset_n, .sfrReq, .sfrRdata, .powerMode, .strobeTick,
        .convRequest, .convAccept, .convDone, .temperatureIrq, .externalVoltageIrq, .powerEventIrq);

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            results();
        end
    end

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // Inputs move 1 ns after the edge, never on it
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Trailing idle cycle keeps back-to-back calls from rewriting a strobe in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrReq = '{a, 1'b1, 1'b0, d};
        step();
        sfrReq = '0;
        step();
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        sfrReq = '{a, 1'b0, 1'b1, 8'h00};
        step();
        sfrReq = '0;
        chk(sfrRdata, exp);
        step();
    endtask : rdchk

    task automatic tick();
        strobeTick = 1'b1;
        step();
        strobeTick = 1'b0;
        step();
    endtask : tick

    task automatic irq(input logic t, input logic v);
        chk({6'h00, temperatureIrq, externalVoltageIrq}, {6'h00, t, v});
    endtask : irq

    // Converter: waits for the request, accepts, reports the code three cycles later
    task automatic convert(input int ch, input logic [7:0] c);
        int n;
        n = 0;
        while (convRequest[ch] !== 1'b1 && n < 40)
        begin
            step();
            n++;
        end
        chk({7'h00, convRequest[ch]}, 8'h01);
        convAccept[ch] = 1'b1;
        step();
        convAccept[ch] = 1'b0;
        repeat (2) step();
        convDone[ch] = '{1'b1, c};
        step();
        convDone[ch] = '{1'b0, ~c};
    endtask : convert

    function automatic logic hit(input logic [7:0] c, input logic [7:0] r, input logic [2:0] s);
        int d;
        d = (c > r) ? c - r : r - c;
        return (s == 3'h7) || (s != 3'h0 && d > s);
    endfunction : hit

    initial
    begin
        int i;
        int ch;
        logic [2:0] s;
        logic [7:0] code;
        logic [7:0] flags;
        logic [7:0] en;
        logic e;
        seed = 34440;
        reset_n = 1'b0;
        sfrReq = '0;
        powerMode = full_power_mode;
        strobeTick = 1'b0;
        convAccept = '0;
        foreach (convDone[k])
            convDone[k] = '{1'b0, 8'h00};
        repeat (5) @(posedge clk);
        #1;
        reset_n = 1'b1;
        step();
        // Registers and one unmapped address read zero after reset
        foreach (addrs[k])
            rdchk(addrs[k], REG_RESET);
        tick();
        repeat (3) step();
        chk({5'h00, convRequest}, 8'h00);
        // One single conversion per channel seeds each reference
        wr(8'hEC, 8'h0C);
        for (i = 0; i < 3; i++)
        begin
            code = 8'($random(seed));
            wr(8'hD8, 8'h01 << i);
            convert(i, code);
            irq(i == 1, i == 2);
            res[i] = code;
            refs[i] = code;
            rdchk(8'hD8, 8'h00);
            rdchk(resAddr[i], code);
            rdchk(8'hF8, (i == 0) ? 8'h04 : 8'h00);
            chk({7'h00, powerEventIrq}, {7'h00, i == 0});
            wr(8'hF8, 8'h00);
        end
        // Background runs on all channels over every delta code, boundary codes on even passes
        wr(8'hFA, 8'h80);
        for (i = 0; i < 16; i++)
        begin
            s = i[3:1];
            en = {4'h0, i[0], i[0], 2'b00};
            wr(8'hF3, {2'b00, s, s});
            wr(8'hEC, en);
            wr(8'hF9, 8'h15);
            tick();
            flags = 8'h00;
            for (ch = 0; ch < 3; ch++)
            begin
                code = i[0] ? 8'($random(seed)) : refs[ch] + s;
                convert(ch, code);
                e = (ch == 0) ? (code < 8'h80) : hit(code, refs[ch], s);
                irq(ch == 1 && e, 1'b0);
                if (e)
                begin
                    res[ch] = code;
                    refs[ch] = code;
                    flags = flags | ((ch == 0) ? 8'h04 : (ch == 2) ? 8'h08 : 8'h00);
                end
            end
            chk({7'h00, powerEventIrq}, {7'h00, |(flags & en)});
            rdchk(8'hF8, flags);
            for (ch = 0; ch < 3; ch++)
                rdchk(resAddr[ch], res[ch]);
            wr(8'hF8, 8'h00);
        end
        // Battery-powered mode drops background work but serves single requests
        powerMode = battery_active_mode;
        tick();
        repeat (3) step();
        chk({5'h00, convRequest}, 8'h00);
        code = 8'($random(seed));
        wr(8'hD8, 8'h02);
        convert(1, code);
        irq(1'b1, 1'b0);
        refs[1] = code;
        // Halted sleep holds a single battery start and runs background temperature
        powerMode = halted_sleep_mode;
        wr(8'hD8, 8'h01);
        tick();
        code = 8'($random(seed));
        convert(1, code);
        irq(hit(code, refs[1], s), 1'b0);
        convert(2, 8'($random(seed)));
        chk({7'h00, convRequest[0]}, 8'h00);
        wr(8'hF8, 8'h00);
        powerMode = full_power_mode;
        code = 8'($random(seed));
        convert(0, code);
        rdchk(8'hF8, 8'h04);
        rdchk(8'hDF, code);
        results();
    end
endmodule : housekeeping_adc_sequencer_test
`default_nettype wire
